/* File: hdl/dacl_pkg.sv */
// constants for the parallel-input dac digital front end
// assumes one 20 MHz system clock and synchronous inputs
// Behaviour
// - a 12-bit straight-binary sample word is taken with one clock, msb on data_msb_input, lsb on data_lsb_input.
// - an all-ones captured code sends full-scale current to the true current output.
// - the complement current output carries the remainder of full scale, so the split follows the code.
// - the input word is captured by an edge-triggered master/slave register, not a transparent latch.
// - the output updates on each rising clock edge, at up to 165 MSPS.
// - any clock duty cycle works when high and low times meet the minimum pulse width.
// - sleep at logic one powers down and turns off the output current.
// - sleep is pulled low internally, so an open sleep input leaves the device converting.
// - power-down completes in under 50 ns and normal output resumes about 5 us after sleep is released.
// - the code is unsigned 0 to 4095 and the true output is code over 4096 of full scale.
package dacl_pkg;
	localparam int          CODE_W         = 12;
	localparam int          FIFO_DEPTH     = 8;
	localparam int          CLK_MHZ        = 20;
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          PDN_MAX_NS     = 50;
	localparam int          WAKE_US        = 5;
	// longest time rounds down, at least one cycle
	localparam int          PDN_CYC_RAW    = PDN_MAX_NS / CLK_PERIOD_NS;
	localparam int          PDN_CYC        = (PDN_CYC_RAW < 1) ? 1 : PDN_CYC_RAW;
	// least time rounds up
	localparam int          WAKE_CYC       = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAKE_W         = 8;
	localparam logic [11:0] CODE_FULL      = 12'hFFF;
	localparam logic [11:0] CODE_ZERO      = 12'h000;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE  = 3'b100
	} dacl_state_e;
endpackage

/* File: hdl/dacl_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module dacl_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;
	logic             in_ready_r, in_ready_nxt;

	always_comb begin
		push   = in_valid_i && in_ready_r;
		pop    = out_valid_o && out_ready_i;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
		end
		if (pop) begin
			rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - (AW+1)'(1);
		end
		// room flag registered from the next count, so it never lags a push
		in_ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			in_ready_r <= 1'b1;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			in_ready_r <= in_ready_nxt;
		end
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	assign in_ready_o  = in_ready_r;
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];
endmodule

/* File: hdl/dacl_split.sv */
// splits the held code into true and complement current codes
// takes the next code combinationally; the caller registers its outputs
`timescale 1ns/100ps
module dacl_split #(
	parameter int CODE_W = 12
) (
	input  wire logic [CODE_W-1:0] code_i,
	input  wire logic              on_i,
	output logic      [CODE_W-1:0] true_o,
	output logic      [CODE_W-1:0] comp_o
);
	always_comb begin
		true_o = on_i ? code_i : '0;
		comp_o = on_i ? ~code_i : '0;    // 4095 - code
	end
endmodule

/* File: hdl/dacl_top.sv */
// front end: sample capture, output code hold and sleep sequencing
// assumes data and sleep synchronous to CLK_I; one conversion per rising edge
`timescale 1ns/100ps
module dacl_top #(
	parameter int CODE_W   = dacl_pkg::CODE_W,
	parameter int DEPTH    = dacl_pkg::FIFO_DEPTH,
	parameter int WAKE_CYC = dacl_pkg::WAKE_CYC
) (
	input  wire logic              CLK_I,
	input  wire logic              SRST_I,
	input  wire logic [CODE_W-1:0] DATA_I,
	input  wire logic              DATA_VALID_I,
	output logic                   DATA_READY_O,
	input  wire logic              SLEEP_I,
	output logic      [CODE_W-1:0] TRUE_CURRENT_OUTPUT_O,
	output logic      [CODE_W-1:0] COMPLEMENT_CURRENT_OUTPUT_O,
	output logic                   SLEEPING_O,
	output logic                   OUT_UPDATE_O
);
	// sleep pull-down: an undriven pin resolves low
	logic                 sleep_in;
	logic                 fifo_in_ready, fifo_out_valid;
	logic [CODE_W-1:0]    fifo_out_data;
	logic [CODE_W-1:0]    code_r, code_nxt;
	logic [CODE_W-1:0]    true_c, comp_c;
	logic [CODE_W-1:0]    true_r, comp_r;
	logic                 upd_r, upd_nxt;
	logic                 sleeping_r, sleeping_nxt;
	logic                 on_nxt;
	dacl_pkg::dacl_state_e state_r, state_nxt;
	logic [15:0]          wake_cnt_r, wake_cnt_nxt;
	logic                 out_on;
	logic                 take;

	assign sleep_in = (SLEEP_I === 1'b1);

	dacl_fifo #(
		.WIDTH (CODE_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.srst_i      (SRST_I),
		.in_data_i   (DATA_I),
		.in_valid_i  (DATA_VALID_I),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_out_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (take)
	);

	// sleep sequencing
	always_comb begin
		state_nxt    = state_r;
		wake_cnt_nxt = wake_cnt_r;
		case (state_r)
			dacl_pkg::ST_RUN: begin
				if (sleep_in) begin
					state_nxt = dacl_pkg::ST_SLEEP;
				end
			end
			dacl_pkg::ST_SLEEP: begin
				if (!sleep_in) begin
					state_nxt    = dacl_pkg::ST_WAKE;
					wake_cnt_nxt = '0;
				end
			end
			dacl_pkg::ST_WAKE: begin
				if (sleep_in) begin
					state_nxt = dacl_pkg::ST_SLEEP;
				end else if (wake_cnt_r >= 16'(WAKE_CYC - 1)) begin
					state_nxt = dacl_pkg::ST_RUN;
				end else begin
					wake_cnt_nxt = wake_cnt_r + 16'h0001;
				end
			end
			default: begin
				state_nxt = dacl_pkg::ST_RUN;
			end
		endcase
		sleeping_nxt = (state_nxt != dacl_pkg::ST_RUN);
	end

	assign out_on = (state_r == dacl_pkg::ST_RUN) && !sleep_in;
	// while sleeping the fifo is not drained, so back-pressure reaches the source
	assign take   = out_on && fifo_out_valid;
	// outputs follow the next state, so the held code shows as soon as waking ends
	assign on_nxt = (state_nxt == dacl_pkg::ST_RUN);

	// edge-triggered capture, held until the next accepted word
	always_comb begin
		code_nxt = code_r;
		upd_nxt  = 1'b0;
		if (take) begin
			code_nxt = fifo_out_data;
			upd_nxt  = 1'b1;
		end
	end

	dacl_split #(
		.CODE_W (CODE_W)
	) u_split (
		.code_i (code_nxt),
		.on_i   (on_nxt),
		.true_o (true_c),
		.comp_o (comp_c)
	);

	// one capture edge only, so the clock duty cycle does not matter
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			state_r    <= dacl_pkg::ST_RUN;
			wake_cnt_r <= '0;
			code_r     <= dacl_pkg::CODE_ZERO;
			upd_r      <= 1'b0;
			true_r     <= '0;
			comp_r     <= '0;
			sleeping_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			code_r     <= code_nxt;
			upd_r      <= upd_nxt;
			true_r     <= true_c;
			comp_r     <= comp_c;
			sleeping_r <= sleeping_nxt;
		end
	end

	assign TRUE_CURRENT_OUTPUT_O       = true_r;
	assign COMPLEMENT_CURRENT_OUTPUT_O = comp_r;
	assign OUT_UPDATE_O                = upd_r;
	assign DATA_READY_O                = fifo_in_ready;
	assign SLEEPING_O                  = sleeping_r;

	// checks
	property p_split_sum;
		@(posedge CLK_I) disable iff (SRST_I)
		(true_r != '0 || comp_r != '0) |-> ((true_r ^ comp_r) == dacl_pkg::CODE_FULL);
	endproperty
	a_split_sum: assert property (p_split_sum) else $error("outputs not complementary");

	property p_full;
		@(posedge CLK_I) disable iff (SRST_I)
		(take && fifo_out_data == dacl_pkg::CODE_FULL) |=> (true_r == dacl_pkg::CODE_FULL && comp_r == '0);
	endproperty
	a_full: assert property (p_full) else $error("full code not full scale");

	property p_capture;
		@(posedge CLK_I) disable iff (SRST_I)
		take |=> (code_r == $past(fifo_out_data) && upd_r);
	endproperty
	a_capture: assert property (p_capture) else $error("word not captured");

	property p_hold;
		@(posedge CLK_I) disable iff (SRST_I)
		!take |=> $stable(code_r);
	endproperty
	a_hold: assert property (p_hold) else $error("code changed without capture");

	property p_sleep_off;
		@(posedge CLK_I) disable iff (SRST_I)
		sleep_in |=> (true_r == '0 && comp_r == '0);
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("current not off in sleep");

	property p_pdn_time;
		@(posedge CLK_I) disable iff (SRST_I)
		$rose(sleep_in) |-> ##[1:1] SLEEPING_O;
	endproperty
	a_pdn_time: assert property (p_pdn_time) else $error("power-down too slow");

	property p_wake_min;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_SLEEP && !sleep_in) |=> SLEEPING_O [*8];
	endproperty
	a_wake_min: assert property (p_wake_min) else $error("woke too early");

	property p_update_rate;
		@(posedge CLK_I) disable iff (SRST_I)
		(out_on && fifo_out_valid) |=> OUT_UPDATE_O;
	endproperty
	a_update_rate: assert property (p_update_rate) else $error("no update on edge");

	property p_code_map;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_RUN && !sleep_in) |=> (true_r == code_r);
	endproperty
	a_code_map: assert property (p_code_map) else $error("true output not code");

	property p_comp_map;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_RUN && !sleep_in) |=> (comp_r == ~code_r);
	endproperty
	a_comp_map: assert property (p_comp_map) else $error("complement output not remainder");

	property p_zero_code;
		@(posedge CLK_I) disable iff (SRST_I)
		(take && fifo_out_data == dacl_pkg::CODE_ZERO) |=> (true_r == '0 && comp_r == dacl_pkg::CODE_FULL);
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("zero code not all on complement");

	property p_msb;
		@(posedge CLK_I) disable iff (SRST_I)
		take |=> (true_r[CODE_W-1] == $past(fifo_out_data[CODE_W-1]) && true_r[0] == $past(fifo_out_data[0]));
	endproperty
	a_msb: assert property (p_msb) else $error("bit order wrong");

	property p_upd_show;
		@(posedge CLK_I) disable iff (SRST_I)
		OUT_UPDATE_O |-> (true_r == code_r);
	endproperty
	a_upd_show: assert property (p_upd_show) else $error("update without new code");

	property p_upd_only_take;
		@(posedge CLK_I) disable iff (SRST_I)
		OUT_UPDATE_O |-> $past(take);
	endproperty
	a_upd_only_take: assert property (p_upd_only_take) else $error("update without a taken word");

	property p_out_hold;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_RUN && !sleep_in && !take) |=> $stable(true_r);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output moved without capture");

	// sleep sequencing checks
	property p_state_onehot;
		@(posedge CLK_I) disable iff (SRST_I)
		$onehot(state_r);
	endproperty
	a_state_onehot: assert property (p_state_onehot) else $error("sleep state not one-hot");

	property p_pdn_fast;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_RUN && sleep_in) |=> (state_r == dacl_pkg::ST_SLEEP && SLEEPING_O);
	endproperty
	a_pdn_fast: assert property (p_pdn_fast) else $error("sleep not entered at once");

	property p_asleep_zero;
		@(posedge CLK_I) disable iff (SRST_I)
		SLEEPING_O |-> (true_r == '0 && comp_r == '0);
	endproperty
	a_asleep_zero: assert property (p_asleep_zero) else $error("current on while asleep");

	property p_no_take_asleep;
		@(posedge CLK_I) disable iff (SRST_I)
		SLEEPING_O |-> !take;
	endproperty
	a_no_take_asleep: assert property (p_no_take_asleep) else $error("word taken while asleep");

	property p_sleep_cnt_clear;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_SLEEP && !sleep_in) |=> (wake_cnt_r == '0);
	endproperty
	a_sleep_cnt_clear: assert property (p_sleep_cnt_clear) else $error("wake count not restarted");

	property p_wake_restart;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_WAKE && sleep_in) |=> (state_r == dacl_pkg::ST_SLEEP);
	endproperty
	a_wake_restart: assert property (p_wake_restart) else $error("sleep ignored while waking");

	property p_wake_bound;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_WAKE) |-> (wake_cnt_r < 16'(WAKE_CYC));
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake count overran");

	property p_wake_end;
		@(posedge CLK_I) disable iff (SRST_I)
		(state_r == dacl_pkg::ST_WAKE && !sleep_in && wake_cnt_r == 16'(WAKE_CYC - 1))
			|=> (state_r == dacl_pkg::ST_RUN && !SLEEPING_O);
	endproperty
	a_wake_end: assert property (p_wake_end) else $error("wake did not end on count");

	property p_wake_show;
		@(posedge CLK_I) disable iff (SRST_I)
		$fell(SLEEPING_O) |-> (true_r == code_r && comp_r == ~code_r);
	endproperty
	a_wake_show: assert property (p_wake_show) else $error("held code not shown after wake");

	c_update: cover property (@(posedge CLK_I) disable iff (SRST_I) take ##1 take);
	c_sleep:  cover property (@(posedge CLK_I) disable iff (SRST_I) $rose(SLEEPING_O));
	c_wake:   cover property (@(posedge CLK_I) disable iff (SRST_I) $fell(SLEEPING_O));
	c_full:   cover property (@(posedge CLK_I) disable iff (SRST_I) !DATA_READY_O);
	c_rewake: cover property (@(posedge CLK_I) disable iff (SRST_I) state_r == dacl_pkg::ST_WAKE && sleep_in);
endmodule

/* File: tb/dacl_src.sv */
// sample source model driving the data port of the front end
// assumes the bench loads words into q; stall_i holds them back
`timescale 1ns/100ps
module dacl_src (
	input  wire logic                        clk_i,
	input  wire logic                        stall_i,
	input  wire logic                        ready_i,
	output logic      [dacl_pkg::CODE_W-1:0] data_o,
	output logic                             valid_o
);
	logic [dacl_pkg::CODE_W-1:0] q[$];
	logic                        took;
	initial begin
		data_o  = 12'h000;
		valid_o = 1'b0;
		took    = 1'b0;
	end
	always @(posedge clk_i) begin
		took = valid_o && ready_i;
	end
	// data moves at the falling edge, away from the capture edge
	always @(negedge clk_i) begin
		if (took)
			q.delete(0);
		if (q.size() > 0 && !stall_i) begin
			valid_o <= 1'b1;
			data_o  <= q[0];
		end else begin
			valid_o <= 1'b0;
			data_o  <= ~data_o;
		end
	end
endmodule

/* File: tb/dacl_top_test.sv */
// self-checking bench for the dac front end
// assumes dacl_top with a short wake count and the dacl_src model
`timescale 1ns/100ps
module dacl_top_test;
	localparam int WAKE = 12;
	logic        clk, srst, sleep, stall, ready, upd, slp, valid;
	logic [11:0] data, tru, cmp, hold;
	logic [11:0] exp_q[$];
	int          fails, checked, cyc;
	dacl_top #(.WAKE_CYC(WAKE)) dut (.CLK_I(clk), .SRST_I(srst), .DATA_I(data), .DATA_VALID_I(valid),
		.DATA_READY_O(ready), .SLEEP_I(sleep), .TRUE_CURRENT_OUTPUT_O(tru),
		.COMPLEMENT_CURRENT_OUTPUT_O(cmp), .SLEEPING_O(slp), .OUT_UPDATE_O(upd));
	dacl_src src (.clk_i(clk), .stall_i(stall), .ready_i(ready), .data_o(data), .valid_o(valid));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic send(input logic [11:0] c);
		src.q.push_back(c);
		exp_q.push_back(c);
	endtask
	task automatic drain;
		for (int i = 0; i < 60 && exp_q.size() != 0; i++)
			@(negedge clk);
		chk(12'(exp_q.size()), 12'h000);
	endtask
	// each update pulse must show the next word taken, and its complement
	always @(negedge clk) begin
		cyc++;
		if (upd === 1'b1 && exp_q.size() > 0) begin
			chk(tru, exp_q[0]);
			chk(cmp, 12'hFFF - exp_q[0]);
			exp_q.delete(0);
		end
		if (cyc > 3000) begin
			fails++;
			close_out();
		end
	end
	task automatic t_codes;
		sleep = 1'bz;
		send(12'h000);
		send(12'hFFF);
		send(12'h800);
		send(12'h001);
		send(12'hA5C);
		drain();
		sleep = 1'b0;
	endtask
	task automatic t_hold;
		stall = 1'b1;
		send(12'h3C3);
		hold = tru;
		repeat (6) begin
			@(negedge clk);
			chk(tru, hold);
			chk({11'h000, upd}, 12'h000);
		end
		stall = 1'b0;
		drain();
	endtask
	task automatic t_sleep;
		sleep = 1'b1;
		@(negedge clk);
		chk(tru, 12'h000);
		chk(cmp, 12'h000);
		chk({11'h000, slp}, 12'h001);
		for (int i = 0; i < 9; i++)
			send(12'h100 + 12'(i));
		repeat (12) @(negedge clk);
		chk({11'h000, ready}, 12'h000);
		chk(tru, 12'h000);
		sleep = 1'b0;
		repeat (WAKE - 2) @(negedge clk);
		chk({11'h000, slp}, 12'h001);
		drain();
		chk({11'h000, slp}, 12'h000);
	endtask
	// sleep again in mid wake: waking restarts, then the held code returns
	task automatic t_rewake;
		hold = tru;
		sleep = 1'b1;
		repeat (3) @(negedge clk);
		sleep = 1'b0;
		repeat (4) @(negedge clk);
		sleep = 1'b1;
		repeat (2) @(negedge clk);
		chk({11'h000, slp}, 12'h001);
		chk(cmp, 12'h000);
		sleep = 1'b0;
		repeat (WAKE - 2) @(negedge clk);
		chk({11'h000, slp}, 12'h001);
		repeat (4) @(negedge clk);
		chk({11'h000, slp}, 12'h000);
		chk(tru, hold);
		chk(cmp, 12'hFFF - hold);
	endtask
	initial begin
		fails = 0;
		checked = 0;
		cyc = 0;
		srst = 1'b1;
		sleep = 1'b0;
		stall = 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk(tru, 12'h000);
		chk({11'h000, ready}, 12'h001);
		t_codes();
		t_hold();
		t_sleep();
		t_rewake();
		close_out();
	end
endmodule
